/* File: hw/pfw_ctrl.sv */
// host-side controller driving a parallel page flash
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "pfw_defines.svh"
module pfw_ctrl #(
  parameter int TWC_CYC = `PFW_TWC_CYC,
  parameter int BYTE_LOAD_WINDOW_CYC = `PFW_BYTE_LOAD_WINDOW_CYC,
  parameter int PAGE_BYTES = 64
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [14:0] flash_addr,
  output logic chip_sel_n,
  output logic out_drive_n,
  output logic write_strobe_n,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in
);
  localparam int CW = 24;
  localparam logic [3:0] TWP = 4'(`PFW_TWP_CYC);
  localparam logic [3:0] TWPH = 4'(`PFW_TWPH_CYC);
  localparam logic [3:0] TOEHP = 4'(`PFW_TOEHP_CYC);

  pfw_pkg::pfw_state_t st_q, st_d; // sequencer state
  logic [14:0] addr_q, addr_d; // target address
  logic [7:0] wdat_q, wdat_d; // byte to load
  logic [7:0] rdat_q, rdat_d; // last byte read
  logic [2:0] cmd_q, cmd_d; // command in progress
  logic [3:0] ph_q, ph_d; // pulse width counter
  logic [CW-1:0] blc_q, blc_d; // cycles since last load
  logic [CW-1:0] wc_q, wc_d; // program cycle watchdog
  logic [6:0] nload_q, nload_d; // loads in this page
  logic loading_q, loading_d; // page load open
  logic busy_q, busy_d, done_q, done_d, tmo_q, tmo_d, late_q, late_d;
  logic prev6_q, prev6_d; // toggle bit of previous poll
  logic first_q, first_d; // first poll read pending
  logic [15:0] rdata_q, rdata_d; // read data register
  logic [7:0] dq_sync; // synchronised data pins
  logic start; // accepted command

  pfw_sync #(.W(8)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din(flash_dq_in),
    .dout(dq_sync)
  );

  // software command accepted only when idle
  assign start = reg_wr && reg_addr == `PFW_REG_CTRL
                 && st_q == pfw_pkg::PFW_IDLE;

  // next-state logic for sequencer and registers
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    cmd_d = cmd_q;
    ph_d = ph_q;
    blc_d = blc_q;
    wc_d = wc_q;
    nload_d = nload_q;
    loading_d = loading_q;
    busy_d = busy_q;
    done_d = done_q;
    tmo_d = tmo_q;
    late_d = late_q;
    prev6_d = prev6_q;
    first_d = first_q;
    // register writes; sticky flags cleared by status write
    if (reg_wr) begin
      case (reg_addr)
        // pins stay put while a pulse runs
        `PFW_REG_ADDR: begin
          if (st_q == pfw_pkg::PFW_IDLE) begin
            addr_d = reg_wdata[14:0];
          end
        end
        `PFW_REG_DATA: begin
          if (st_q == pfw_pkg::PFW_IDLE) begin
            wdat_d = reg_wdata[7:0];
          end
        end
        `PFW_REG_STAT: begin
          done_d = 1'b0;
          tmo_d = 1'b0;
          late_d = 1'b0;
        end
        default: ;
      endcase
    end
    // window since last load, counts while page open
    if (loading_q && blc_q != CW'(BYTE_LOAD_WINDOW_CYC)) begin
      blc_d = blc_q + CW'(1);
    end
    case (st_q)
      pfw_pkg::PFW_IDLE: begin
        if (start) begin
          cmd_d = reg_wdata[2:0];
          ph_d = 4'h0;
          case (reg_wdata[2:0])
            `PFW_CMD_LOAD: begin
              // command series go out as plain loads
              if (loading_q && blc_q == CW'(BYTE_LOAD_WINDOW_CYC)) begin
                late_d = 1'b1; // window missed
                loading_d = 1'b0;
                nload_d = 7'h00;
              end
              st_d = pfw_pkg::PFW_WLOW;
            end
            `PFW_CMD_READ: st_d = pfw_pkg::PFW_RLOW;
            `PFW_CMD_POLL: begin
              first_d = 1'b1;
              wc_d = '0;
              busy_d = 1'b1;
              loading_d = 1'b0;
              st_d = pfw_pkg::PFW_RLOW;
            end
            `PFW_CMD_ENDPG: begin
              // stop loading; device starts cycle on first read frame
              loading_d = 1'b0;
              nload_d = 7'h00;
              first_d = 1'b1;
              wc_d = '0;
              busy_d = 1'b1;
              st_d = pfw_pkg::PFW_RLOW;
            end
            default: st_d = pfw_pkg::PFW_IDLE;
          endcase
        end
      end
      // write strobe low with drive off
      pfw_pkg::PFW_WLOW: begin
        ph_d = ph_q + 4'h1;
        if (ph_q == TWP - 4'h1) begin
          ph_d = 4'h0;
          st_d = pfw_pkg::PFW_WHIGH;
        end
      end
      // strobe high: address hold and pulse high time
      pfw_pkg::PFW_WHIGH: begin
        ph_d = ph_q + 4'h1;
        if (ph_q == TWPH - 4'h1) begin
          ph_d = 4'h0;
          loading_d = 1'b1;
          blc_d = '0; // restart load window
          if (nload_q != 7'(PAGE_BYTES)) begin
            nload_d = nload_q + 7'h01; // count toward full page
          end
          st_d = pfw_pkg::PFW_DONE;
        end
      end
      // read pulse: drive and select low
      pfw_pkg::PFW_RLOW: begin
        ph_d = ph_q + 4'h1;
        if (cmd_q != `PFW_CMD_READ) begin
          wc_d = wc_q + CW'(1);
        end
        if (ph_q == TOEHP - 4'h1) begin
          ph_d = 4'h0;
          rdat_d = dq_sync;
          st_d = pfw_pkg::PFW_RHIGH;
        end
      end
      // high gap between reads makes the toggle advance
      pfw_pkg::PFW_RHIGH: begin
        ph_d = ph_q + 4'h1;
        if (cmd_q != `PFW_CMD_READ) begin
          wc_d = wc_q + CW'(1);
        end
        if (ph_q == TOEHP - 4'h1) begin
          ph_d = 4'h0;
          st_d = (cmd_q == `PFW_CMD_READ) ? pfw_pkg::PFW_DONE
                                          : pfw_pkg::PFW_POLL;
        end
      end
      // compare toggle bit with previous read only
      pfw_pkg::PFW_POLL: begin
        prev6_d = rdat_q[6];
        first_d = 1'b0;
        if (!first_q && rdat_q[6] == prev6_q) begin
          busy_d = 1'b0; // cycle over
          st_d = pfw_pkg::PFW_DONE;
        end else if (wc_q >= CW'(TWC_CYC)) begin
          busy_d = 1'b0;
          tmo_d = 1'b1;
          st_d = pfw_pkg::PFW_DONE;
        end else begin
          st_d = pfw_pkg::PFW_RLOW; // same address again
        end
      end
      pfw_pkg::PFW_DONE: begin
        done_d = 1'b1;
        st_d = pfw_pkg::PFW_IDLE;
      end
      default: st_d = pfw_pkg::PFW_IDLE;
    endcase
  end

  // register read mux, data one cycle after strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `PFW_REG_CTRL: rdata_d = {13'h0000, cmd_q};
        `PFW_REG_ADDR: rdata_d = {1'b0, addr_q};
        `PFW_REG_DATA: rdata_d = {8'h00, wdat_q};
        `PFW_REG_STAT: begin
          rdata_d[`PFW_ST_BUSY] = (st_q != pfw_pkg::PFW_IDLE) || busy_q;
          rdata_d[`PFW_ST_DONE] = done_q;
          rdata_d[`PFW_ST_TMO] = tmo_q;
          rdata_d[`PFW_ST_LATE] = late_q;
        end
        `PFW_REG_RDAT: rdata_d = {8'h00, rdat_q};
        `PFW_REG_CNT: rdata_d = {9'h000, nload_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= pfw_pkg::PFW_IDLE;
      addr_q <= 15'h0000;
      wdat_q <= 8'h00;
      rdat_q <= 8'h00;
      cmd_q <= 3'h0;
      ph_q <= 4'h0;
      blc_q <= '0;
      wc_q <= '0;
      nload_q <= 7'h00;
      loading_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      tmo_q <= 1'b0;
      late_q <= 1'b0;
      prev6_q <= 1'b0;
      first_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      cmd_q <= cmd_d;
      ph_q <= ph_d;
      blc_q <= blc_d;
      wc_q <= wc_d;
      nload_q <= nload_d;
      loading_q <= loading_d;
      busy_q <= busy_d;
      done_q <= done_d;
      tmo_q <= tmo_d;
      late_q <= late_d;
      prev6_q <= prev6_d;
      first_q <= first_d;
      rdata_q <= rdata_d;
    end
  end

  // pin drive from state; address held whole cycle
  assign flash_addr = addr_q;
  assign chip_sel_n = !(st_q == pfw_pkg::PFW_WLOW
                        || st_q == pfw_pkg::PFW_RLOW);
  assign write_strobe_n = (st_q != pfw_pkg::PFW_WLOW);
  assign out_drive_n = (st_q != pfw_pkg::PFW_RLOW);
  assign flash_dq_out = wdat_q;
  assign flash_dq_oe = (st_q == pfw_pkg::PFW_WLOW
                        || st_q == pfw_pkg::PFW_WHIGH);
  assign reg_rdata = rdata_q;
endmodule : pfw_ctrl

/* File: hw/pfw_defines.svh */
// timing counts, register offsets and field positions for the flash writer
`ifndef PFW_DEFINES_SVH
`define PFW_DEFINES_SVH
`define PFW_CLK_MHZ 50
`define PFW_TWP_NS 90
`define PFW_TWPH_NS 100
`define PFW_TAH_NS 50
`define PFW_TDS_NS 35
`define PFW_TOEHP_NS 150
`define PFW_BYTE_LOAD_WINDOW_US 150
`define PFW_TWC_MS 10
// least times round up, longest time rounds down
`define PFW_TWP_CYC ((`PFW_TWP_NS * `PFW_CLK_MHZ + 999) / 1000)
`define PFW_TWPH_CYC ((`PFW_TWPH_NS * `PFW_CLK_MHZ + 999) / 1000)
`define PFW_TAH_CYC ((`PFW_TAH_NS * `PFW_CLK_MHZ + 999) / 1000)
`define PFW_TOEHP_CYC ((`PFW_TOEHP_NS * `PFW_CLK_MHZ + 999) / 1000)
`define PFW_BYTE_LOAD_WINDOW_CYC (`PFW_BYTE_LOAD_WINDOW_US * `PFW_CLK_MHZ)
`define PFW_TWC_CYC (`PFW_TWC_MS * 1000 * `PFW_CLK_MHZ)
// software register offsets
`define PFW_REG_CTRL 4'h0
`define PFW_REG_ADDR 4'h1
`define PFW_REG_DATA 4'h2
`define PFW_REG_STAT 4'h3
`define PFW_REG_RDAT 4'h4
`define PFW_REG_CNT 4'h5
// ctrl command codes
`define PFW_CMD_LOAD 3'h1
`define PFW_CMD_READ 3'h2
`define PFW_CMD_POLL 3'h3
`define PFW_CMD_ENDPG 3'h4
// status bit positions
`define PFW_ST_BUSY 0
`define PFW_ST_DONE 1
`define PFW_ST_TMO 2
`define PFW_ST_LATE 3
`endif

/* File: hw/pfw_pkg.sv */
// types for the page flash write controller
package pfw_pkg;
  typedef enum logic [6:0] {
    PFW_IDLE = 7'h01,
    PFW_WLOW = 7'h02,
    PFW_WHIGH = 7'h04,
    PFW_RLOW = 7'h08,
    PFW_RHIGH = 7'h10,
    PFW_POLL = 7'h20,
    PFW_DONE = 7'h40
  } pfw_state_t;
endpackage : pfw_pkg

/* File: hw/pfw_sync.sv */
// three-flop input synchroniser for the flash data pins
`timescale 1ns/10ps
module pfw_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, hold_q;
  logic [W-1:0] s1_d, s2_d, s3_d, hold_d;
  // next values; a change counts once stages two and three agree
  always_comb begin
    s1_d = din;
    s2_d = s1_q;
    s3_d = s2_q;
    hold_d = hold_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        hold_d[i] = s3_q[i];
      end
    end
  end
  // register stages
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      hold_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      hold_q <= hold_d;
    end
  end
  assign dout = hold_q;
endmodule : pfw_sync

/* File: test/pfw_ctrl_asserts.sv */
// pin timing checks for the flash write controller
`timescale 1ns/10ps
module pfw_ctrl_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [14:0] flash_addr,
  input wire logic chip_sel_n,
  input wire logic out_drive_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe
);
  // one clock domain, reset disables all
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_OE_IN_WRITE: assert property (!write_strobe_n |-> out_drive_n)
    else $error("output drive low in write pulse");
  AST_DQ_NO_FIGHT: assert property (flash_dq_oe |-> out_drive_n)
    else $error("data driven during read");
  AST_WR_LOW: assert property ($fell(write_strobe_n) |->
    (!write_strobe_n && !chip_sel_n && flash_dq_oe)[*5] ##1 write_strobe_n)
    else $error("write pulse length");
  AST_WR_HIGH: assert property ($rose(write_strobe_n) |->
    (write_strobe_n && flash_dq_oe)[*5] ##1 !flash_dq_oe)
    else $error("write high phase");
  AST_PAGE_ADDR: assert property (
    !write_strobe_n |-> $stable(flash_addr))
    else $error("address moved in pulse");
  AST_DQ_HOLD: assert property (flash_dq_oe |-> $stable(flash_dq_out))
    else $error("data moved while driven");
  AST_RD_LOW: assert property ($fell(out_drive_n) |->
    (!out_drive_n && !chip_sel_n)[*8] ##1 out_drive_n)
    else $error("read frame length");
  AST_RD_HIGH: assert property (
    $rose(out_drive_n) |-> out_drive_n[*8])
    else $error("output drive high pulse");
  AST_POLL_ADDR: assert property (
    !out_drive_n |-> $stable(flash_addr))
    else $error("address moved in read");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside slot");
endmodule : pfw_ctrl_chk
bind pfw_ctrl pfw_ctrl_chk chk_u (.clk(clk), .reset_n(reset_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
  .chip_sel_n(chip_sel_n), .out_drive_n(out_drive_n),
  .write_strobe_n(write_strobe_n), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe));

/* File: test/pfw_flash_model.sv */
// behavioural model of the parallel page flash
`timescale 1ns/10ps
module pfw_flash_model #(
  parameter int BUSY_CYC = 300,
  parameter int SLOW_CYC = 3000,
  parameter logic [7:0] PROT_ON = 8'hA5, // arbitrary value
  parameter logic [7:0] PROT_OFF = 8'h5A, // arbitrary value
  parameter logic [14:0] ID_ADDR = 15'h5555,
  parameter logic [7:0] ID_ENTER = 8'h90,
  parameter logic [7:0] ID_EXIT = 8'hF0,
  parameter logic [7:0] MAKER = 8'h3C, // arbitrary value
  parameter logic [7:0] PART = 8'hC3 // arbitrary value
) (
  input wire logic clk,
  input wire logic slow_prog,
  input wire logic [14:0] flash_addr,
  input wire logic chip_sel_n,
  input wire logic out_drive_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  output logic [7:0] flash_dq_in
);
  logic [7:0] mem [0:32767]; // array contents, erased reads FF
  logic [63:0] ld_mask; // bytes loaded in the open page
  logic [14:0] la; // latched load address
  logic [7:0] wlast, rdv, last_q;
  logic tog, id_mode, loading, prot, pend, prot_next;
  logic wr_act, rd_act; // write pulse and read frame
  int busy; // program cycles left
  // either strobe may end the pulse; both rise together here
  assign wr_act = !write_strobe_n && !chip_sel_n;
  assign rd_act = !out_drive_n && !chip_sel_n;
  // power-up in normal read mode, unprotected
  initial begin
    id_mode = 1'b0;
    {tog, loading, prot, pend, prot_next} = '0;
    {busy, last_q, rdv, wlast, la} = '0;
    ld_mask = '0;
    for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
  end
  // address taken as the pulse begins
  always @(posedge wr_act) la = flash_addr;
  // data taken as the pulse ends; command loads decoded
  always @(negedge wr_act) begin
    if (out_drive_n && busy == 0) begin
      if (la == ID_ADDR && flash_dq_out == ID_ENTER) begin
        id_mode = 1'b1;
      end else if (la == ID_ADDR && flash_dq_out == ID_EXIT) begin
        id_mode = 1'b0;
      end else if (la == ID_ADDR && flash_dq_out == PROT_ON) begin
        {pend, prot_next} = 2'b11;
      end else if (la == ID_ADDR && flash_dq_out == PROT_OFF) begin
        {pend, prot_next} = 2'b10;
      end else if (!prot || pend) begin
        mem[la] = flash_dq_out;
        ld_mask[la[5:0]] = 1'b1;
        wlast = flash_dq_out;
        loading = 1'b1;
      end
    end
  end
  // read frame starts the program cycle and flips toggle bit
  always @(posedge rd_act) begin
    if (loading) begin
      busy = slow_prog ? SLOW_CYC : BUSY_CYC;
      // bytes left out of the page come back unknown
      for (int i = 0; i < 64; i++) begin
        if (!ld_mask[i]) mem[{la[14:6], 6'(i)}] = 'x;
      end
      ld_mask = '0;
    end
    loading = 1'b0;
    tog = ~tog;
  end
  // program timer, protection change at cycle end, read value
  always @(posedge clk) begin
    if (busy == 1 && pend) begin
      prot = prot_next;
      pend = 1'b0;
    end
    if (busy > 0) busy = busy - 1;
    last_q <= ~last_q;
    if (id_mode) rdv = flash_addr[0] ? PART : MAKER;
    else if (busy > 0) rdv = {~wlast[7], tog, 6'h00};
    else rdv = mem[flash_addr];
  end
  // released bus flips every cycle so stale data never looks settled
  assign flash_dq_in = flash_dq_oe ? flash_dq_out :
    rd_act ? rdv : last_q;
endmodule : pfw_flash_model

/* File: test/tb_top.sv */
// register-level testbench for the flash write controller
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic slow_prog = 1'b0; // model runs a long program cycle
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, s;
  logic [14:0] flash_addr;
  logic chip_sel_n, out_drive_n, write_strobe_n, flash_dq_oe;
  logic [7:0] flash_dq_out, flash_dq_in;
  int error_cnt = 0, num_checks = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  pfw_ctrl #(.TWC_CYC(2000), .BYTE_LOAD_WINDOW_CYC(200)) dut_u (.clk(clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_addr(flash_addr), .chip_sel_n(chip_sel_n),
    .out_drive_n(out_drive_n), .write_strobe_n(write_strobe_n),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in));
  pfw_flash_model flash_u (.clk(clk), .slow_prog(slow_prog),
    .flash_addr(flash_addr),
    .chip_sel_n(chip_sel_n), .out_drive_n(out_drive_n),
    .write_strobe_n(write_strobe_n), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in));
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  // one flash command, bounded wait for idle
  task automatic op(input logic [14:0] a, input logic [7:0] d,
    input logic [2:0] c);
    int n;
    wr(4'h1, {1'b0, a});
    wr(4'h2, {8'h00, d});
    wr(4'h0, {13'h0000, c});
    for (n = 0; n < 3000; n++) begin
      rd(4'h3, s);
      if (s[0] === 1'b0) break;
    end
    if (n == 3000) begin
      error_cnt++;
      results();
    end
  endtask : op
  // read one byte back through the controller
  task automatic rdbyte(input logic [14:0] a, input logic [7:0] exp);
    op(a, 8'h00, 3'h2);
    rd(4'h4, s);
    chk({8'h00, s[7:0]}, {8'h00, exp});
  endtask : rdbyte
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(4'h3, s);
    chk(s, 16'h0000);
    rd(4'hF, s);
    chk(s, 16'h0000);
    $display("reset test done");
    // page load of four bytes then end of page with polling
    for (int i = 0; i < 4; i++) op(15'h0040 + 15'(i), 8'hA0 + 8'(i), 3'h1);
    rd(4'h5, s);
    chk(s, 16'h0004);
    wr(4'h3, 16'h0000);
    op(15'h0043, 8'hA3, 3'h4);
    rd(4'h3, s);
    chk({12'h000, s[3:0]}, 16'h0002);
    rd(4'h4, s);
    chk({8'h00, s[7:0]}, 16'h00A3);
    for (int i = 0; i < 4; i++) rdbyte(15'h0040 + 15'(i), 8'hA0 + 8'(i));
    $display("page test done");
    // identification mode entry, codes, exit
    op(15'h5555, 8'h90, 3'h1);
    rdbyte(15'h0000, 8'h3C);
    rdbyte(15'h0001, 8'hC3);
    op(15'h5555, 8'hF0, 3'h1);
    rdbyte(15'h0041, 8'hA1);
    $display("id test done");
    // protection on takes effect after its program cycle
    op(15'h5555, 8'hA5, 3'h1);
    op(15'h00C0, 8'h11, 3'h1);
    op(15'h00C0, 8'h11, 3'h4);
    rdbyte(15'h00C0, 8'h11);
    op(15'h00C0, 8'h22, 3'h1);
    rdbyte(15'h00C0, 8'h11);
    // protection off, then a plain page lands again
    op(15'h5555, 8'h5A, 3'h1);
    op(15'h00C0, 8'h33, 3'h1);
    op(15'h00C0, 8'h33, 3'h4);
    rdbyte(15'h00C0, 8'h33);
    op(15'h00C0, 8'h44, 3'h1);
    op(15'h00C0, 8'h44, 3'h4);
    rdbyte(15'h00C0, 8'h44);
    $display("protection test done");
    // slow program cycle: poll gives up, plain poll then ends it
    @(posedge clk);
    slow_prog <= 1'b1;
    op(15'h0100, 8'h77, 3'h1);
    wr(4'h3, 16'h0000);
    op(15'h0100, 8'h77, 3'h4);
    rd(4'h3, s);
    chk({12'h000, s[3:0]}, 16'h0006);
    wr(4'h3, 16'h0000);
    op(15'h0100, 8'h77, 3'h3);
    rd(4'h3, s);
    chk({12'h000, s[3:0]}, 16'h0002);
    rd(4'h4, s);
    chk({8'h00, s[7:0]}, 16'h0077);
    $display("timeout test done");
    // missed load window
    wr(4'h3, 16'h0000);
    op(15'h0080, 8'h55, 3'h1);
    repeat (250) @(posedge clk);
    op(15'h0081, 8'h56, 3'h1);
    rd(4'h3, s);
    chk({15'h0000, s[3]}, 16'h0001);
    rd(4'h5, s);
    chk(s, 16'h0001);
    $display("window test done");
    results();
  end
endmodule : tb_top
